/* File: core/sph_pkg.sv */
/*
  constants, field layouts and state codes of the serial profile
  command handler; assumes a byte-wide host command stream
*/
//
// Contract
// - start command activates the profile directly
// - role from role pin, stored role if floating
// - disabling hides profile attributes, others keep handles
// - attributes stay hidden until enabled or pin asserted
// - enable 0 off, 1 on, 2 auto-start; default 2
// - role 0 peripheral default, 1 central
// - hold 16-bit company id for advertising data
// - peripheral presents stored 32-bit local key
// - central connects only on masked remote key match
// - pipe open limits sleep by profile level
// - lower system-wide sleep level wins
// - client writes need configured encryption and bonding
// - flag bit0 acked, bit1 rx flow; default 0x02
// - auto-start may signal advertising or scanning event
// - get command returns all stored settings
package sph_pkg;
  // -------------------------------------------------------------
  // frame header
  // -------------------------------------------------------------
  localparam logic [7:0] FR_TYPE = 8'h00_C0;
  localparam logic [7:0] FR_GROUP = 8'h00_0A;
  localparam logic [7:0] ID_START = 8'h00_02;
  localparam logic [7:0] ID_SET = 8'h00_03;
  localparam logic [7:0] ID_GET = 8'h00_04;
  localparam logic [7:0] LEN_START = 8'h00_00;
  localparam logic [7:0] LEN_SET = 8'h00_13;
  localparam logic [7:0] LEN_GET = 8'h00_01;
  localparam logic [7:0] LEN_RSP = 8'h00_02;
  localparam logic [7:0] LEN_RSP_GET = 8'h00_15;
  localparam int HDR_BYTES = 4;
  localparam int PAY_BITS = 152;
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_BAD_PARAM = 16'h0001;
  localparam logic [15:0] RES_DISABLED = 16'h0002;
  // -------------------------------------------------------------
  // setting codes and defaults
  // -------------------------------------------------------------
  localparam logic [7:0] EN_OFF = 8'h00_00;
  localparam logic [7:0] EN_ON = 8'h00_01;
  localparam logic [7:0] EN_AUTO = 8'h00_02;
  localparam logic [7:0] ROLE_CENTRAL = 8'h00_01;
  localparam logic [7:0] SLEEP_MAX = 8'h00_02;
  localparam logic [7:0] SEC_MAX = 8'h00_03;
  localparam logic [7:0] FLAGS_DEF = 8'h00_02;
  // arbitrary neutral company id, not any maker's code
  localparam logic [15:0] COMPANY_DEF = 16'h1234;
  // -------------------------------------------------------------
  // apb map
  // -------------------------------------------------------------
  localparam logic [7:0] A_STAT = 8'h00_00;
  localparam logic [7:0] A_MASK = 8'h00_04;
  localparam logic [7:0] A_STATE = 8'h00_08;
  localparam int ST_BITS = 4;
  typedef enum logic [2:0] {
    S_TYPE = 3'b000, S_LEN = 3'b001, S_GRP = 3'b011, S_ID = 3'b010,
    S_PAY = 3'b110, S_EXEC = 3'b111, S_RESP = 3'b101
  } sph_state_t;
endpackage

/* File: core/sph_handler.sv */
/*
  serial profile command handler: parses host frames, stores the
  profile settings, answers, and drives the profile's control outputs.
  assumes rx/tx bytes on mclk, pins asynchronous, an apb master.
*/
// The implementer's own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sph_handler
  import sph_pkg::*;
(
  input wire logic mclk, // 40 MHz clock
  input wire logic nrst, // async reset, low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // unmapped access
  input wire logic [7:0] rx_data, // command byte
  input wire logic rx_valid, // command byte valid
  output logic rx_ready, // handler takes byte
  output logic [7:0] tx_data, // response byte
  output logic tx_valid, // response byte valid
  input wire logic tx_ready, // host takes byte
  input wire logic role_select_pin, // role pin level
  input wire logic role_pin_driven, // role pin not floating
  input wire logic profile_pin, // profile pin
  input wire logic pipe_open, // data pipe open
  input wire logic [1:0] sys_sleep, // system sleep level
  input wire logic link_encrypted, // link encrypted
  input wire logic link_bonded, // peer bonded
  input wire logic [31:0] peer_key, // advertised peer key
  output logic peer_match, // peer may be connected
  output logic profile_active, // profile running
  output logic role_central, // running as central
  output logic attr_hidden, // attribute range hidden
  output logic advertising_state_event, // pulse
  output logic scanning_state_event, // pulse
  output logic [15:0] company_id, // manufacturer data id
  output logic [31:0] local_key, // key while advertising
  output logic [1:0] sleep_limit, // allowed sleep level
  output logic write_allow, // client writes accepted
  output logic ack_xfer, // acknowledged transfers
  output logic rx_flow_ctrl, // rx flow control on
  output logic irq // interrupt, high
);
  // -------------------------------------------------------------
  // pin synchronisers
  // -------------------------------------------------------------
  logic [2:0] pin_m_q, pin_s_q;
  logic prof_d1_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
      prof_d1_q <= 1'b0;
    end else begin
      pin_m_q <= {profile_pin, role_pin_driven, role_select_pin};
      pin_s_q <= pin_m_q;
      prof_d1_q <= pin_s_q[2];
    end
  end
  wire logic pin_rise = pin_s_q[2] & ~prof_d1_q;

  // -------------------------------------------------------------
  // frame parser
  // -------------------------------------------------------------
  sph_state_t st_q;
  logic [7:0] len_q, id_q, cnt_q, idx_q, rlen_q;
  logic [PAY_BITS-1:0] pay_q;
  logic [15:0] res_q;
  logic [7:0] en_q, role_q, sleep_q, sec_q, flags_q;
  logic [15:0] comp_q;
  logic [31:0] lkey_q, rkey_q, mask_q;
  logic bad_frame, cmd_ok;

  // stored role passed in, so a continuous assign sees every change of it
  function automatic logic role_central_sel(input logic [7:0] r);
    return r == ROLE_CENTRAL;
  endfunction
  // a floating pin falls back on the stored role
  wire logic start_role = pin_s_q[1] ? pin_s_q[0] : role_central_sel(role_q);

  assign rx_ready = (st_q != S_EXEC) && (st_q != S_RESP);
  wire logic rx_take = rx_valid & rx_ready;
  wire logic tx_take = tx_valid & tx_ready;
  // a frame for this group with the length its id demands
  assign cmd_ok = (id_q == ID_START && len_q == LEN_START) ||
                  (id_q == ID_SET && len_q == LEN_SET) ||
                  (id_q == ID_GET && len_q == LEN_GET);
  assign bad_frame = (st_q == S_EXEC) && !cmd_ok;

  // header, then payload bytes counted by the length byte
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_TYPE;
      len_q <= '0;
      id_q <= '0;
      cnt_q <= '0;
      pay_q <= '0;
    end else begin
      unique case (st_q)
        S_TYPE: if (rx_take && rx_data == FR_TYPE) st_q <= S_LEN;
        S_LEN: if (rx_take) begin
          len_q <= rx_data;
          st_q <= S_GRP;
        end
        S_GRP: if (rx_take) begin
          id_q <= (rx_data == FR_GROUP) ? id_q : 8'h00_00;
          st_q <= (rx_data == FR_GROUP) ? S_ID : S_TYPE;
        end
        S_ID: if (rx_take) begin
          id_q <= rx_data;
          cnt_q <= '0;
          st_q <= (len_q == LEN_START) ? S_EXEC : S_PAY;
        end
        // bytes beyond the payload field are counted but dropped
        S_PAY: if (rx_take) begin
          if (cnt_q < LEN_SET) pay_q[cnt_q*8 +: 8] <= rx_data;
          cnt_q <= cnt_q + 8'h00_01;
          if (cnt_q == len_q - 8'h00_01) st_q <= S_EXEC;
        end
        S_EXEC: st_q <= cmd_ok ? S_RESP : S_TYPE;
        S_RESP: if (tx_take && idx_q == rlen_q + 8'(HDR_BYTES - 1)) st_q <= S_TYPE;
        default: st_q <= S_TYPE;
      endcase
    end
  end

  // -------------------------------------------------------------
  // settings store and command effects
  // -------------------------------------------------------------
  wire logic [7:0] p_en = pay_q[7:0];
  wire logic [7:0] p_role = pay_q[15:8];
  wire logic [7:0] p_sleep = pay_q[135:128];
  wire logic [7:0] p_sec = pay_q[143:136];
  wire logic param_ok = p_en <= EN_AUTO && p_role <= ROLE_CENTRAL &&
                        p_sleep <= SLEEP_MAX && p_sec <= SEC_MAX;
  wire logic do_set = (st_q == S_EXEC) && cmd_ok && id_q == ID_SET;
  wire logic do_start = (st_q == S_EXEC) && cmd_ok && id_q == ID_START;
  wire logic set_ok = do_set && param_ok;
  wire logic start_ok = do_start && en_q != EN_OFF;
  wire logic auto_go = set_ok && p_en == EN_AUTO;
  wire logic go = start_ok || auto_go || pin_rise;

  // stored settings, power-on defaults
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_q <= EN_AUTO;
      role_q <= '0;
      comp_q <= COMPANY_DEF;
      lkey_q <= '0;
      rkey_q <= '0;
      mask_q <= '0;
      sleep_q <= SLEEP_MAX;
      sec_q <= '0;
      flags_q <= FLAGS_DEF;
    end else if (set_ok) begin
      en_q <= p_en;
      role_q <= p_role;
      comp_q <= pay_q[31:16];
      lkey_q <= pay_q[63:32];
      rkey_q <= pay_q[95:64];
      mask_q <= pay_q[127:96];
      sleep_q <= p_sleep;
      sec_q <= p_sec;
      flags_q <= pay_q[151:144];
    end else if (pin_rise && en_q == EN_OFF) begin
      en_q <= EN_ON; // pin re-enables the profile
    end
  end

  // activity, role and attribute visibility
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      profile_active <= 1'b0;
      role_central <= 1'b0;
      attr_hidden <= 1'b0;
      advertising_state_event <= 1'b0;
      scanning_state_event <= 1'b0;
    end else begin
      advertising_state_event <= go && !start_role;
      scanning_state_event <= go && start_role;
      if (set_ok && p_en == EN_OFF) begin
        profile_active <= 1'b0;
        attr_hidden <= 1'b1;
      end else if (go) begin
        profile_active <= 1'b1;
        role_central <= start_role;
        attr_hidden <= 1'b0;
      end else if (set_ok) begin
        attr_hidden <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------
  // response frame
  // -------------------------------------------------------------
  wire logic [PAY_BITS-1:0] cfg_vec = {flags_q, sec_q, sleep_q, mask_q, rkey_q,
                                       lkey_q, comp_q, role_q, en_q};

  function automatic logic [7:0] rsp_byte(input logic [7:0] i);
    logic [7:0] k;
    k = i - 8'(HDR_BYTES + 2);
    unique case (i)
      8'h00_00: return FR_TYPE;
      8'h00_01: return rlen_q;
      8'h00_02: return FR_GROUP;
      8'h00_03: return id_q;
      8'h00_04: return res_q[7:0];
      8'h00_05: return res_q[15:8];
      default: return (k < LEN_SET) ? cfg_vec[k*8 +: 8] : 8'h00_00;
    endcase
  endfunction

  // result code and length fixed at execute, bytes fed on handshake
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      res_q <= RES_OK;
      rlen_q <= '0;
      idx_q <= '0;
      tx_data <= '0;
    end else if (st_q == S_EXEC) begin
      res_q <= (do_set && !param_ok) ? RES_BAD_PARAM :
               (do_start && en_q == EN_OFF) ? RES_DISABLED : RES_OK;
      rlen_q <= (id_q == ID_GET) ? LEN_RSP_GET : LEN_RSP;
      idx_q <= '0;
      tx_data <= FR_TYPE;
    end else if (tx_take) begin
      idx_q <= idx_q + 8'h00_01;
      tx_data <= rsp_byte(idx_q + 8'h00_01);
    end
  end
  assign tx_valid = (st_q == S_RESP);

  // -------------------------------------------------------------
  // link policy outputs
  // -------------------------------------------------------------
  // registered so the radio side sees glitch-free levels
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      peer_match <= 1'b0;
      sleep_limit <= '0;
      write_allow <= 1'b0;
      ack_xfer <= 1'b0;
      rx_flow_ctrl <= 1'b0;
    end else begin
      peer_match <= profile_active && role_central &&
                    ((peer_key ^ rkey_q) & mask_q) == '0;
      if (pipe_open && sleep_q[1:0] < sys_sleep) sleep_limit <= sleep_q[1:0];
      else sleep_limit <= sys_sleep;
      write_allow <= (!sec_q[0] || link_encrypted) && (!sec_q[1] || link_bonded);
      ack_xfer <= role_central && flags_q[0];
      rx_flow_ctrl <= role_central && flags_q[1];
    end
  end
  assign company_id = comp_q;
  assign local_key = lkey_q;

  // -------------------------------------------------------------
  // apb slave and interrupt
  // -------------------------------------------------------------
  logic [ST_BITS-1:0] stat_q, mask_irq_q;
  wire logic [ST_BITS-1:0] ev = {do_set && !param_ok, bad_frame, go, st_q == S_EXEC && cmd_ok};
  wire logic wr = psel && penable && pwrite;
  wire logic mapped = paddr == A_STAT || paddr == A_MASK || paddr == A_STATE;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // sticky events: a set in the clearing cycle survives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
      mask_irq_q <= '0;
    end else begin
      stat_q <= (stat_q & ~((wr && paddr == A_STAT) ? pwdata[ST_BITS-1:0] : '0)) | ev;
      if (wr && paddr == A_MASK) mask_irq_q <= pwdata[ST_BITS-1:0];
    end
  end
  assign irq = |(stat_q & mask_irq_q);

  // read data captured in the setup phase, zero wait
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) prdata <= '0;
    else if (psel && !penable) begin
      unique case (paddr)
        A_STAT: prdata <= 32'(stat_q);
        A_MASK: prdata <= 32'(mask_irq_q);
        A_STATE: prdata <= {21'h00_0000, attr_hidden, role_central, profile_active, en_q};
        default: prdata <= '0;
      endcase
    end
  end

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_start_active: assert property (start_ok |=> profile_active)
    else $error("start did not activate");
  chk_role_pin: assert property (go && pin_s_q[1] |=> role_central == $past(pin_s_q[0]))
    else $error("role not from pin");
  chk_hide_off: assert property (set_ok && p_en == EN_OFF |=> attr_hidden && !profile_active)
    else $error("disable did not hide");
  chk_hidden_holds: assert property (attr_hidden && !go && !set_ok |=> attr_hidden)
    else $error("attributes unhidden early");
  // masked key compare, written out apart from the registered match
  wire logic key_hit = ((peer_key ^ rkey_q) & mask_q) == '0;
  chk_peer_key: assert property (peer_match |-> $past(role_central && key_hit))
    else $error("peer match without key");
  chk_sleep_cap: assert property (##1 sleep_limit <= $past(sys_sleep))
    else $error("sleep above system level");
  chk_write_sec: assert property (sec_q == SEC_MAX && !link_bonded |=> !write_allow)
    else $error("write allowed unbonded");
  chk_event_role: assert property (go |=> advertising_state_event ^ scanning_state_event)
    else $error("no state event");
  chk_resp_frame: assert property (st_q == S_EXEC && cmd_ok |=> tx_valid && tx_data == FR_TYPE)
    else $error("no response");
  // policy, lengths, pin enable, sticky status and advertising event
  chk_rx_flow: assert property (role_central && flags_q[1] |=> rx_flow_ctrl)
    else $error("rx flow control off");
  chk_get_len: assert property (st_q == S_EXEC && id_q == ID_GET
    |=> rlen_q == LEN_RSP_GET)
    else $error("get response length wrong");
  chk_pin_enable: assert property (pin_rise && en_q == EN_OFF && !set_ok
    |=> en_q == EN_ON)
    else $error("pin did not re-enable");
  chk_stat_sticky: assert property (ev[0] |=> stat_q[0])
    else $error("done status lost");
  chk_adv_role: assert property (go && !start_role |=> advertising_state_event)
    else $error("no advertising event");
endmodule // sph_handler
`default_nettype wire

/* File: sim/sph_host_model.sv */
/*
  host model: offers command frames byte by byte and drains response
  frames, optionally stalling each response byte.
  assumes the handler's byte handshakes on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module sph_host_model (
  input wire logic mclk, // bench clock
  output logic [7:0] rx_data, // command byte
  output logic rx_valid, // byte offered
  input wire logic rx_ready, // handler takes byte
  input wire logic [7:0] tx_data, // response byte
  input wire logic tx_valid, // response offered
  output logic tx_ready // host takes byte
);
  int n_to = 0;
  int stall = 0;
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'h0;
    tx_ready = 1'h0;
  end
  // -------------------------------------------------------------
  // command side
  // -------------------------------------------------------------
  // byte held until taken; released line shows inverse, not a stale copy
  task automatic send(input logic [7:0] f[$]);
    int n;
    @(posedge mclk);
    foreach (f[i]) begin
      rx_data <= f[i];
      rx_valid <= 1'h1;
      n = 0;
      do begin @(posedge mclk); n++; end while (rx_ready !== 1'h1 && n < 64);
      if (n >= 64) n_to++;
    end
    rx_valid <= 1'h0;
    rx_data <= ~f[f.size()-1];
  endtask
  // -------------------------------------------------------------
  // response side
  // -------------------------------------------------------------
  // stall keeps ready low so the handler must hold each byte
  task automatic recv(input int cnt, output logic [7:0] r[$]);
    int n;
    r = {};
    repeat (cnt) begin
      repeat (stall) @(posedge mclk);
      tx_ready <= 1'h1;
      n = 0;
      do begin @(posedge mclk); n++; end while (tx_valid !== 1'h1 && n < 64);
      if (n >= 64) n_to++;
      r.push_back(tx_data);
      if (stall > 0) tx_ready <= 1'h0;
    end
    if (stall == 0) tx_ready <= 1'h0;
  endtask
endmodule // sph_host_model
`default_nettype wire

/* File: sim/tb_top.sv */
/*
  testbench: frames commands through the host model, reads registers
  over apb and moves the pins; assumes sph_pkg and sph_handler.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sph_pkg::*;
  logic mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, rx_data, tx_data;
  logic [31:0] pwdata, prdata, peer_key, local_key, rd;
  logic rx_valid, rx_ready, tx_valid, tx_ready, role_select_pin, role_pin_driven;
  logic profile_pin, pipe_open, link_encrypted, link_bonded, peer_match;
  logic profile_active, role_central, attr_hidden, advertising_state_event;
  logic scanning_state_event, write_allow, ack_xfer, rx_flow_ctrl, irq;
  logic [1:0] sys_sleep, sleep_limit;
  logic [15:0] company_id;
  logic [7:0] pq[$], rq[$];
  int n_fail = 0, checks_done = 0, n_adv = 0, n_scan = 0;
  sph_handler dut (.*);
  sph_host_model host (.*);
  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end
  // event pulses are counted so a single-cycle pulse is never missed
  always @(posedge mclk) begin
    if (advertising_state_event === 1'h1) n_adv++;
    if (scanning_state_event === 1'h1) n_scan++;
  end
  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  // zero-wait slave, but the wait is still bounded, never assumed
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin @(posedge mclk); n++; end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin n_fail++; close_out(); end
  endtask
  task automatic cmd(input logic [7:0] id, len, rlen, input logic [15:0] res);
    logic [7:0] f[$];
    f = {FR_TYPE, len, FR_GROUP, id};
    host.send({f, pq});
    host.recv(rlen + 4, rq);
    if (host.n_to != 0) begin n_fail++; close_out(); end
    chk({rq[0], rq[1], rq[2], rq[3]}, {FR_TYPE, rlen, FR_GROUP, id});
    chk({rq[5], rq[4]}, res);
  endtask
  // set payload, multi-byte fields little-endian
  task automatic mkset(input logic [7:0] en, ro, input logic [15:0] co,
                       input logic [31:0] lk, rk, mk, input logic [7:0] sl, se, fl);
    logic [111:0] v;
    v = {mk, rk, lk, co};
    pq = {en, ro};
    for (int i = 0; i < 14; i++) pq.push_back(v[8*i +: 8]);
    pq = {pq, sl, se, fl};
  endtask
  task automatic getchk();
    logic [7:0] e[$];
    e = pq;
    pq = {8'h00};
    cmd(ID_GET, LEN_GET, LEN_RSP_GET, RES_OK);
    for (int i = 0; i < 19; i++) chk(rq[6+i], e[i]);
  endtask
  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    nrst = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0; paddr = 8'h00;
    pwdata = 32'h0; role_select_pin = 1'h0; role_pin_driven = 1'h1;
    profile_pin = 1'h0; pipe_open = 1'h0; sys_sleep = 2'h2; link_encrypted = 1'h0;
    link_bonded = 1'h0; peer_key = 32'h0;
    repeat (16) @(posedge mclk);
    nrst <= 1'h1;
    settle(2);
    chk(write_allow, 1);
    @(posedge mclk);
    apb(1, A_MASK, 32'h0000_000F);
    apb(0, A_STATE, 32'h0);
    chk(rd, 32'h0000_0002);
    chk(company_id, COMPANY_DEF);
    mkset(EN_AUTO, 8'h00, COMPANY_DEF, 32'h0, 32'h0, 32'h0, SLEEP_MAX, 8'h00, FLAGS_DEF);
    getchk();
    $display("test defaults done");
    mkset(8'h03, 8'h00, COMPANY_DEF, 32'h0, 32'h0, 32'h0, SLEEP_MAX, 8'h00, FLAGS_DEF);
    cmd(ID_SET, LEN_SET, LEN_RSP, RES_BAD_PARAM);
    apb(0, A_STAT, 32'h0);
    chk(rd & 32'h8, 32'h8);
    chk(irq, 1);
    apb(1, A_STAT, 32'h0000_000F);
    apb(0, A_STAT, 32'h0);
    chk(rd, 32'h0);
    chk(irq, 0);
    // a get with length 0 must be swallowed without an answer
    host.send({FR_TYPE, 8'h00, FR_GROUP, ID_GET});
    settle(4);
    chk(tx_valid, 0);
    @(posedge mclk);
    apb(0, A_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    $display("test refusals done");
    host.stall = 3;
    mkset(EN_ON, ROLE_CENTRAL, 16'hBEEF, 32'hA5A5_0001, 32'h1234_5678, 32'hFFFF_0000,
          8'h01, SEC_MAX, 8'h01);
    cmd(ID_SET, LEN_SET, LEN_RSP, RES_OK);
    host.stall = 0;
    getchk();
    chk(company_id, 16'hBEEF);
    chk(local_key, 32'hA5A5_0001);
    chk(attr_hidden, 0);
    pq = {};
    cmd(ID_START, LEN_START, LEN_RSP, RES_OK);
    chk(profile_active, 1);
    chk(role_central, 0);
    chk(n_adv > 0, 1);
    role_pin_driven <= 1'h0;
    repeat (4) @(posedge mclk);
    cmd(ID_START, LEN_START, LEN_RSP, RES_OK);
    chk(role_central, 1);
    chk(n_scan > 0, 1);
    chk(ack_xfer, 1);
    chk(rx_flow_ctrl, 0);
    $display("test settings and start done");
    peer_key <= 32'h1234_FFFF;
    settle(3);
    chk(peer_match, 1);
    @(posedge mclk);
    peer_key <= 32'h1334_5678;
    settle(3);
    chk(peer_match, 0);
    @(posedge mclk);
    pipe_open <= 1'h1;
    settle(3);
    chk(sleep_limit, 1);
    @(posedge mclk);
    sys_sleep <= 2'h0;
    settle(3);
    chk(sleep_limit, 0);
    @(posedge mclk);
    link_encrypted <= 1'h1;
    settle(3);
    chk(write_allow, 0);
    @(posedge mclk);
    link_bonded <= 1'h1;
    settle(3);
    chk(write_allow, 1);
    $display("test link outputs done");
    @(posedge mclk);
    mkset(EN_OFF, 8'h00, 16'hBEEF, 32'h0, 32'h0, 32'h0, SLEEP_MAX, 8'h00, FLAGS_DEF);
    cmd(ID_SET, LEN_SET, LEN_RSP, RES_OK);
    chk(attr_hidden, 1);
    pq = {};
    cmd(ID_START, LEN_START, LEN_RSP, RES_DISABLED);
    chk(attr_hidden, 1);
    profile_pin <= 1'h1;
    settle(6);
    chk(attr_hidden, 0);
    @(posedge mclk);
    apb(0, 8'h0C, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    $display("test disable and unmapped done");
    close_out();
  end
  // watchdog against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    close_out();
  end
endmodule // tb_top
`default_nettype wire
